// [design/cmp_lut.sv]
/*
 * four programmable two-input lookup tables fed by comparator outputs,
 * with registered results toward the configurable_logic_array routing.
 * assumes: comparator outputs are asynchronous to clk_sys; the config
 * port is driven by logic on clk_sys; clk_sys runs at 10 MHz.
 */
// Behaviour
// - four independent two-input, one-output tables
// - inputs taken from any of four comparators
// - any comparator may be operand A or B
// - table outputs drive the logic-array routing interface
// - routing carries them onward to fabric consumers
// - each function set by a 4-bit control word
// - constants, pass and invert words per encoding
// - and/or mixed-polarity words per encoding
// - xor, nor, xnor, nand words per encoding
`timescale 1ns/1ns
module cmp_lut (
   // clock, reset, enable
   input  wire logic                             clk_sys,
   input  wire logic                             rst_n,
   input  wire logic                             ce,
   // configuration write port
   input  wire logic                             cfg_we,
   input  wire logic [cmp_lut_pkg::IDX_W-1:0]    cfg_idx,
   input  wire logic [cmp_lut_pkg::CW_W-1:0]     cfg_word,
   input  wire logic [cmp_lut_pkg::SEL_W-1:0]    cfg_sel_a,
   input  wire logic [cmp_lut_pkg::SEL_W-1:0]    cfg_sel_b,
   // comparator outputs, asynchronous
   input  wire logic [cmp_lut_pkg::NUM_CMP-1:0]  cmp_in,
   // results toward the logic-array routing interface
   output logic      [cmp_lut_pkg::NUM_LUT-1:0]  lut_out
);

   localparam int NL = cmp_lut_pkg::NUM_LUT;
   localparam int NC = cmp_lut_pkg::NUM_CMP;

   // synchroniser stages; meta is read only by sync
   logic [NC-1:0] meta_q, meta_d;
   logic [NC-1:0] sync_q, sync_d;

   // configuration storage, one entry per unit
   logic [cmp_lut_pkg::CW_W-1:0]  word_q  [NL];
   logic [cmp_lut_pkg::CW_W-1:0]  word_d  [NL];
   logic [cmp_lut_pkg::SEL_W-1:0] sela_q  [NL];
   logic [cmp_lut_pkg::SEL_W-1:0] sela_d  [NL];
   logic [cmp_lut_pkg::SEL_W-1:0] selb_q  [NL];
   logic [cmp_lut_pkg::SEL_W-1:0] selb_d  [NL];

   // operands and registered results
   logic [NL-1:0] op_a;                // selected operand A per unit
   logic [NL-1:0] op_b;                // selected operand B per unit
   logic [NL-1:0] out_q, out_d;

   // next state of the synchroniser; ce freezes it like all else
   always_comb begin
      meta_d = meta_q;
      sync_d = sync_q;
      if (ce) begin
         meta_d = cmp_in;
         sync_d = meta_q;
      end
   end

   // register the synchroniser
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   // comparator levels reach the tables exactly two enabled edges late;
   // the reset guard skips edges whose sync stage still holds reset
   a_sync_depth: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ($past(ce) && $past(ce, 2) && $past(rst_n) && $past(rst_n, 2))
      |-> sync_q == $past(cmp_in, 2))
      else $error("comparator synchroniser depth wrong");

   // per-unit configuration and evaluation
   for (genvar i = 0; i < NL; i++) begin : g_lut
      localparam logic [cmp_lut_pkg::IDX_W-1:0] ID =
         cmp_lut_pkg::IDX_W'(i);

      // operand muxes: any comparator to either input
      assign op_a[i] = sync_q[sela_q[i]];
      assign op_b[i] = sync_q[selb_q[i]];

      // next config: a write to this index replaces all three fields
      always_comb begin
         word_d[i] = word_q[i];
         sela_d[i] = sela_q[i];
         selb_d[i] = selb_q[i];
         if (ce && cfg_we && (cfg_idx == ID)) begin
            word_d[i] = cfg_word;
            sela_d[i] = cfg_sel_a;
            selb_d[i] = cfg_sel_b;
         end
      end

      // next output: the word is read as a truth table, so every
      // encoding falls out of one mux with no decode to get wrong
      // (constants, pass, invert, and/or, xor families)
      always_comb begin
         out_d[i] = out_q[i];
         if (ce) begin
            out_d[i] = word_q[i][{~op_a[i], ~op_b[i]}];
         end
      end

      // register config and result; reset leaves words zero
      always_ff @(posedge clk_sys) begin
         if (!rst_n) begin
            word_q[i] <= cmp_lut_pkg::CW_RESET;
            sela_q[i] <= cmp_lut_pkg::SEL_RESET;
            selb_q[i] <= cmp_lut_pkg::SEL_RESET;
            out_q[i]  <= cmp_lut_pkg::OUT_RESET;
         end else begin
            word_q[i] <= word_d[i];
            sela_q[i] <= sela_d[i];
            selb_q[i] <= selb_d[i];
            out_q[i]  <= out_d[i];
         end
      end

      // constant, pass and invert words
      a_fn_basic: assert property (@(posedge clk_sys) disable iff (!rst_n)
         ce |=> out_q[i] == (
            ($past(word_q[i]) == cmp_lut_pkg::CW_FALSE) ? 1'b0 :
            ($past(word_q[i]) == cmp_lut_pkg::CW_TRUE)  ? 1'b1 :
            ($past(word_q[i]) == cmp_lut_pkg::CW_A)  ? $past(op_a[i]) :
            ($past(word_q[i]) == cmp_lut_pkg::CW_B)  ? $past(op_b[i]) :
            ($past(word_q[i]) == cmp_lut_pkg::CW_NA) ? !$past(op_a[i]) :
            ($past(word_q[i]) == cmp_lut_pkg::CW_NB) ? !$past(op_b[i]) :
            out_q[i]))
         else $error("constant or pass function wrong");

      // and/or family with mixed polarity
      a_fn_andor: assert property (@(posedge clk_sys) disable iff (!rst_n)
         (ce && (word_q[i] == cmp_lut_pkg::CW_AND ||
                 word_q[i] == cmp_lut_pkg::CW_A_NB ||
                 word_q[i] == cmp_lut_pkg::CW_NA_B ||
                 word_q[i] == cmp_lut_pkg::CW_OR ||
                 word_q[i] == cmp_lut_pkg::CW_A_OR_NB ||
                 word_q[i] == cmp_lut_pkg::CW_NA_OR_B))
         |=> out_q[i] == (
            ($past(word_q[i]) == cmp_lut_pkg::CW_AND) ?
               ($past(op_a[i]) && $past(op_b[i])) :
            ($past(word_q[i]) == cmp_lut_pkg::CW_A_NB) ?
               ($past(op_a[i]) && !$past(op_b[i])) :
            ($past(word_q[i]) == cmp_lut_pkg::CW_NA_B) ?
               (!$past(op_a[i]) && $past(op_b[i])) :
            ($past(word_q[i]) == cmp_lut_pkg::CW_OR) ?
               ($past(op_a[i]) || $past(op_b[i])) :
            ($past(word_q[i]) == cmp_lut_pkg::CW_A_OR_NB) ?
               ($past(op_a[i]) || !$past(op_b[i])) :
               (!$past(op_a[i]) || $past(op_b[i]))))
         else $error("and/or function wrong");

      // exclusive and negated families
      a_fn_xor: assert property (@(posedge clk_sys) disable iff (!rst_n)
         (ce && (word_q[i] == cmp_lut_pkg::CW_XOR ||
                 word_q[i] == cmp_lut_pkg::CW_NOR ||
                 word_q[i] == cmp_lut_pkg::CW_XNOR ||
                 word_q[i] == cmp_lut_pkg::CW_NAND))
         |=> out_q[i] == (
            ($past(word_q[i]) == cmp_lut_pkg::CW_XOR) ?
               ($past(op_a[i]) ^ $past(op_b[i])) :
            ($past(word_q[i]) == cmp_lut_pkg::CW_NOR) ?
               !($past(op_a[i]) || $past(op_b[i])) :
            ($past(word_q[i]) == cmp_lut_pkg::CW_XNOR) ?
               !($past(op_a[i]) ^ $past(op_b[i])) :
               !($past(op_a[i]) && $past(op_b[i]))))
         else $error("xor/nor/xnor/nand function wrong");

      // operands A and B follow the comparators that their selects name
      a_sel_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
         ($past(ce) && $past(ce, 2) && $past(rst_n) && $past(rst_n, 2) &&
          sela_q[i] == $past(sela_q[i], 2) &&
          selb_q[i] == $past(selb_q[i], 2))
         |-> (op_a[i] == $past(cmp_in[sela_q[i]], 2)) &&
             (op_b[i] == $past(cmp_in[selb_q[i]], 2)))
         else $error("operand select does not track comparator");

      // a write reaches only its own unit, one edge later
      a_cfg_store: assert property (@(posedge clk_sys) disable iff (!rst_n)
         (ce && cfg_we && cfg_idx == ID) |=>
            (word_q[i] == $past(cfg_word)) &&
            (sela_q[i] == $past(cfg_sel_a)) &&
            (selb_q[i] == $past(cfg_sel_b)))
         else $error("control word not stored");

      a_cfg_other: assert property (@(posedge clk_sys) disable iff (!rst_n)
         !(ce && cfg_we && cfg_idx == ID) |=> $stable(word_q[i]))
         else $error("control word changed without its write");

      // a write with enable low, or to another unit, leaves the selects
      a_sel_other: assert property (@(posedge clk_sys) disable iff (!rst_n)
         !(ce && cfg_we && cfg_idx == ID) |=>
            $stable(sela_q[i]) && $stable(selb_q[i]))
         else $error("operand select changed without its write");
   end

   // results leave from flops onto the routing interface
   assign lut_out = out_q;

   // reset leaves every output low and the first and last words zero
   a_reset_low: assert property (@(posedge clk_sys) disable iff (1'b0)
      !rst_n |=> (lut_out == '0) && (word_q[0] == cmp_lut_pkg::CW_RESET) &&
                 (word_q[NL-1] == cmp_lut_pkg::CW_RESET))
      else $error("outputs not low after reset");

   // unconfigured outputs stay low for the two cycles after reset
   a_idle_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ($past(!rst_n) && !cfg_we) |-> (lut_out == '0) [*2])
      else $error("output rose before configuration");

   // enable low freezes every result
   a_ce_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !ce |=> $stable(lut_out) && $stable(sync_q))
      else $error("state moved while enable low");

endmodule : cmp_lut

// [design/cmp_lut_pkg.sv]
/*
 * constants shared by the comparator lookup-table logic: counts, widths,
 * reset values and the named control words of the logic functions.
 * assumes nothing of its surroundings; it holds definitions only.
 */
package cmp_lut_pkg;

   // structure
   localparam int NUM_LUT = 4;      // lookup-table units
   localparam int NUM_CMP = 4;      // comparator outputs feeding them
   localparam int CW_W    = 4;      // control word width
   localparam int SEL_W   = 2;      // comparator select width
   localparam int IDX_W   = 2;      // unit index width
   localparam int SYNC_LAT = 2;     // flops between pin and logic

   // reset values: every output held low until configured
   localparam logic [CW_W-1:0]  CW_RESET  = 4'h0;
   localparam logic [SEL_W-1:0] SEL_RESET = 2'h0;
   localparam logic             OUT_RESET = 1'h0;

   // control words; bit {~a,~b} of the word is the output
   localparam logic [CW_W-1:0] CW_FALSE   = 4'h0;
   localparam logic [CW_W-1:0] CW_AND     = 4'h1;
   localparam logic [CW_W-1:0] CW_A_NB    = 4'h2;
   localparam logic [CW_W-1:0] CW_A       = 4'h3;
   localparam logic [CW_W-1:0] CW_NA_B    = 4'h4;
   localparam logic [CW_W-1:0] CW_B       = 4'h5;
   localparam logic [CW_W-1:0] CW_XOR     = 4'h6;
   localparam logic [CW_W-1:0] CW_OR      = 4'h7;
   localparam logic [CW_W-1:0] CW_NOR     = 4'h8;
   localparam logic [CW_W-1:0] CW_XNOR    = 4'h9;
   localparam logic [CW_W-1:0] CW_NB      = 4'hA;
   localparam logic [CW_W-1:0] CW_A_OR_NB = 4'hB;
   localparam logic [CW_W-1:0] CW_NA      = 4'hC;
   localparam logic [CW_W-1:0] CW_NA_OR_B = 4'hD;
   localparam logic [CW_W-1:0] CW_NAND    = 4'hE;
   localparam logic [CW_W-1:0] CW_TRUE    = 4'hF;

endpackage : cmp_lut_pkg

// [tb/cmp_lut_tb_top.sv]
/*
 * self-checking bench for the comparator lookup tables.
 * assumes the comparator source model and a 10 MHz clk_sys.
 */
`timescale 1ns/1ns
module cmp_lut_tb_top;
   logic       clk_sys;          // system clock
   logic       rst_n;            // synchronous reset, active low
   logic       ce;               // clock enable
   logic       cfg_we;           // config write strobe
   logic [1:0] cfg_idx;          // unit written
   logic [3:0] cfg_word;         // truth table
   logic [1:0] cfg_sel_a;        // operand A comparator
   logic [1:0] cfg_sel_b;        // operand B comparator
   logic [3:0] level_req;        // levels the model should show
   logic [3:0] cmp_in;           // comparator outputs
   logic [3:0] lut_out;          // routed results
   int         err_total;        // mismatches seen
   int         samples_checked;  // comparisons made
   logic [3:0] m_word [4];       // shadow of the stored words
   logic [1:0] m_sa   [4];       // shadow of operand A selects
   logic [1:0] m_sb   [4];       // shadow of operand B selects

   cmp_src_model i_src (.level_req(level_req), .cmp_in(cmp_in));
   cmp_lut i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
      .cfg_we(cfg_we), .cfg_idx(cfg_idx), .cfg_word(cfg_word),
      .cfg_sel_a(cfg_sel_a), .cfg_sel_b(cfg_sel_b), .cmp_in(cmp_in),
      .lut_out(lut_out));

   // 100 ns period
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // reference function, written from the list of named functions so
   // that it shares nothing with the truth-table mux in the design
   function automatic logic lut_ref(input logic [3:0] w, input logic a,
                                    input logic b);
      logic r;
      case (w)
         cmp_lut_pkg::CW_FALSE:   r = 1'h0;
         cmp_lut_pkg::CW_AND:     r = a & b;
         cmp_lut_pkg::CW_A_NB:    r = a & ~b;
         cmp_lut_pkg::CW_A:       r = a;
         cmp_lut_pkg::CW_NA_B:    r = ~a & b;
         cmp_lut_pkg::CW_B:       r = b;
         cmp_lut_pkg::CW_XOR:     r = a ^ b;
         cmp_lut_pkg::CW_OR:      r = a | b;
         cmp_lut_pkg::CW_NOR:     r = ~(a | b);
         cmp_lut_pkg::CW_XNOR:    r = ~(a ^ b);
         cmp_lut_pkg::CW_NB:      r = ~b;
         cmp_lut_pkg::CW_A_OR_NB: r = a | ~b;
         cmp_lut_pkg::CW_NA:      r = ~a;
         cmp_lut_pkg::CW_NA_OR_B: r = ~a | b;
         cmp_lut_pkg::CW_NAND:    r = ~(a & b);
         default:                 r = 1'h1;  // only the all-ones word left
      endcase
      return r;
   endfunction : lut_ref

   // expected results of all units for given comparator levels
   function automatic logic [3:0] exp_all(input logic [3:0] lv);
      logic [3:0] e;
      for (int u = 0; u < 4; u++) begin
         e[u] = lut_ref(m_word[u], lv[m_sa[u]], lv[m_sb[u]]);
      end
      return e;
   endfunction : exp_all

   // reset leaves every word and select zero in the shadow as well
   task automatic model_clear;
      for (int u = 0; u < 4; u++) begin
         m_word[u] = cmp_lut_pkg::CW_RESET;
         m_sa[u]   = cmp_lut_pkg::SEL_RESET;
         m_sb[u]   = cmp_lut_pkg::SEL_RESET;
      end
   endtask : model_clear

   task automatic chk(input string what, input logic [3:0] exp);
      samples_checked++;
      if (lut_out !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, lut_out);
      end
   endtask : chk

   // strobe stays high so writes may follow back to back
   task automatic wr(input int u, input int w, input int sa, input int sb);
      @(posedge clk_sys);
      #1;
      cfg_we    = 1'b1;
      cfg_idx   = 2'(u);
      cfg_word  = 4'(w);
      cfg_sel_a = 2'(sa);
      cfg_sel_b = 2'(sb);
      // a write given with enable low is refused; the shadow ignores it too
      if (ce) begin
         m_word[u] = 4'(w);
         m_sa[u]   = 2'(sa);
         m_sb[u]   = 2'(sb);
      end
   endtask : wr

   // drop the strobe, then let the 3-edge comparator path settle
   task automatic idle(input int n);
      @(posedge clk_sys);
      #1;
      cfg_we = 1'b0;
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : idle

   // every word on differing units, every operand pair
   task automatic t_table;
      logic [3:0] exp;
      for (int w = 0; w < 16; w++) begin
         for (int u = 0; u < 4; u++) wr(u, (w + 5 * u) % 16, 0, 1);
         for (int ab = 0; ab < 4; ab++) begin
            level_req = 4'(ab);
            idle(4);
            for (int u = 0; u < 4; u++)
               exp[u] = lut_ref(4'((w + 5 * u) % 16), ab[0], ab[1]);
            chk("table", exp);
         end
      end
   endtask : t_table

   // any comparator as A or B, equal selects included; units that keep
   // older words are judged through the shadow copy
   task automatic t_select;
      for (int s = 0; s < 4; s++) begin
         for (int t = 0; t < 4; t++) begin
            wr(s, cmp_lut_pkg::CW_A_NB, s, t);
            level_req = 4'(1 << s);
            idle(4);
            chk("select", exp_all(level_req));
            level_req = ~4'(1 << t);
            idle(4);
            chk("select", exp_all(level_req));
         end
      end
   endtask : t_select

   // enable low freezes the comparator path, writes and results alike
   task automatic t_enable;
      wr(0, cmp_lut_pkg::CW_A, 0, 0);
      wr(1, cmp_lut_pkg::CW_FALSE, 0, 0);
      wr(2, cmp_lut_pkg::CW_NA, 1, 1);
      wr(3, cmp_lut_pkg::CW_B, 2, 3);
      level_req = 4'h0;
      idle(4);
      chk("enable high", exp_all(4'h0));
      ce = 1'b0;
      level_req = 4'hF;
      wr(1, cmp_lut_pkg::CW_TRUE, 3, 3);
      idle(4);
      chk("enable low", exp_all(4'h0));
      ce = 1'b1;
      idle(4);
      chk("enable back", exp_all(4'hF));
   endtask : t_enable

   // outputs forced high, then a reset in mid-run clears every word
   task automatic t_reset;
      for (int u = 0; u < 4; u++) wr(u, 4'hF, u, u);
      idle(4);
      chk("forced high", 4'hF);
      rst_n = 1'b0;
      model_clear();
      idle(2);
      rst_n = 1'b1;
      idle(4);
      chk("after reset", 4'h0);
   endtask : t_reset

   task automatic report_and_stop;
      if (err_total == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : report_and_stop

   // watchdog: a hang counts as a mismatch
   initial begin
      #(100 * 50000);
      err_total++;
      report_and_stop();
   end

   initial begin
      err_total = 0;
      samples_checked = 0;
      rst_n = 1'b0;
      ce = 1'b1;
      cfg_we = 1'b0;
      cfg_idx = 2'h0;
      cfg_word = 4'h0;
      cfg_sel_a = 2'h0;
      cfg_sel_b = 2'h0;
      level_req = 4'hF;
      model_clear();
      repeat (12) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      idle(4);
      chk("reset value", 4'h0);
      t_table();
      t_select();
      t_enable();
      t_reset();
      report_and_stop();
   end
endmodule : cmp_lut_tb_top

// [tb/cmp_src_model.sv]
/*
 * behavioural model of the four analog comparators feeding the tables.
 * assumes the bench sets the wanted levels; they reach the pins after a
 * skew that has no relation to clk_sys, like a real comparator edge.
 */
`timescale 1ns/1ns
module cmp_src_model (
   // levels wanted by the bench
   input  wire logic [cmp_lut_pkg::NUM_CMP-1:0] level_req,
   // comparator outputs toward the tables
   output logic      [cmp_lut_pkg::NUM_CMP-1:0] cmp_in
);
   // comparator decision lags its input; 7 ns keeps it off the edge
   assign #7 cmp_in = level_req;
endmodule : cmp_src_model
